// ==== rtl/pmif_flag_bank.sv ====
// one bank of sticky write-one-to-clear flags with its mask register
`timescale 1ns/100ps
`default_nettype none
`include "pmif_regs.svh"
module pmif_flag_bank
  import pmif_pkg::*;
#(
  parameter logic [7:0] FLAG_BITS = 8'hff,
  parameter logic [7:0] MASK_WR   = 8'hff,
  parameter logic [7:0] MASK_RST  = 8'hff
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic [7:0] src,
  input  wire logic [7:0] preset,
  input  wire logic       wr_flags,
  input  wire logic       wr_masks,
  input  wire logic [7:0] wdata,
  output logic      [7:0] flags_q,
  output logic      [7:0] masks_q,
  output logic            pend
);
  pmif_bank_st_t st_reg;
  pmif_bank_st_t st_next;
  logic [7:0]    evt;
  logic [7:0]    clr;

  // rising source edges set flags; set beats a same-cycle clear
  always_comb begin
    st_next       = st_reg;
    evt           = en ? (src & ~st_reg.src_d) : 8'h00;
    clr           = wr_flags ? wdata : 8'h00;
    st_next.src_d = src;
    st_next.flags = ((st_reg.flags & ~clr) | evt | preset) & FLAG_BITS;
    if (wr_masks) begin
      st_next.masks = (st_reg.masks & ~MASK_WR) | (wdata & MASK_WR);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{flags: 8'h00, masks: MASK_RST, src_d: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags_q = st_reg.flags;
  assign masks_q = st_reg.masks;
  assign pend    = |(st_reg.flags & ~st_reg.masks);

  // a set flag survives unless a one was written to it
  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
    1'h1 |=> ((($past(st_reg.flags) & ~$past(clr)) & ~st_reg.flags) == 8'h00);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  // an event during a clear write keeps its flag
  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    (|(evt & clr)) |=> ((st_reg.flags & $past(evt)) == $past(evt & FLAG_BITS));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  // bits outside the mask field never move
  property p_mask_fixed;
    @(posedge clk) disable iff (!rst_n)
    ((st_reg.masks & ~MASK_WR) == (MASK_RST & ~MASK_WR)) && ((st_reg.flags & ~FLAG_BITS) == 8'h00);
  endproperty
  a_mask_fixed: assert property (p_mask_fixed) else $error("unused bit changed");
endmodule // pmif_flag_bank
`default_nettype wire

// ==== rtl/pmif_sync.sv ====
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module pmif_sync
  import pmif_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } pmif_sync_st_t;

  pmif_sync_st_t st_reg;
  pmif_sync_st_t st_next;

  // first stage feeds only the second
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule // pmif_sync
`default_nettype wire

// ==== rtl/pmif_top.sv ====
// interrupt status, mask and live registers reached over a serial two-wire slave
`timescale 1ns/100ps
`default_nettype none
`include "pmif_regs.svh"
module pmif_top
  import pmif_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `PMIF_I2C_ADDR_DFLT
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  output logic            IRQ_OUT_N,
  input  wire logic       POWER_BUTTON_IN,
  input  wire logic       UNDERVOLTAGE_IN,
  input  wire logic [3:0] TEMP_ABOVE_IN,
  input  wire logic       TEST_STRAP_PIN,
  input  wire logic       FUSE_SUPPLY_PIN,
  input  wire logic       FRONT_END_SUPPLY_PIN,
  input  wire logic [3:0] BUCK_OC_IN,
  input  wire logic       BOOST_OC_IN,
  input  wire logic       FRONT_END_OV_IN,
  input  wire logic       FUSE_PROG_RUNNING_IN,
  input  wire logic       FUSE_ECC_IN,
  input  wire logic [5:0] LINEAR_OC_IN
);
  pmif_pins_t   raw;
  pmif_pins_t   ps;
  logic [$bits(pmif_pins_t)-1:0] ps_vec;
  pmif_top_st_t st_reg;
  pmif_top_st_t st_next;

  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       boot_done;
  logic [7:0] rx_byte;
  logic [7:0] rd_val;
  logic       wr_en;
  logic       wr_bf;
  logic       wr_bm;
  logic       wr_sf;
  logic       wr_sm;
  logic       wr_lf;
  logic       wr_lm;
  logic [7:0] buck_live;
  logic [7:0] boost_live;
  logic [7:0] lin_live;
  logic [7:0] buck_src;
  logic [7:0] boost_src;
  logic [7:0] boost_preset;
  logic       strap_hit;
  logic [7:0] bf_q;
  logic [7:0] bm_q;
  logic [7:0] sf_q;
  logic [7:0] sm_q;
  logic [7:0] lf_q;
  logic [7:0] lm_q;
  logic       bp;
  logic       sp;
  logic       lp;

  // gather all outside pins, then synchronise them together
  always_comb begin
    raw.scl                  = SCL_IN;
    raw.sda                  = SDA_IN;
    raw.front_end_supply_pin = FRONT_END_SUPPLY_PIN;
    raw.s0.fuse_supply_live  = FUSE_SUPPLY_PIN;
    raw.s0.test_strap_live   = TEST_STRAP_PIN;
    raw.s0.temp_live         = TEMP_ABOVE_IN;
    raw.s0.undervoltage_live = UNDERVOLTAGE_IN;
    raw.s0.button_level_live = POWER_BUTTON_IN;
    raw.buck_oc              = BUCK_OC_IN;
    raw.boost_oc             = BOOST_OC_IN;
    raw.front_end_ov         = FRONT_END_OV_IN;
    raw.fuse_running         = FUSE_PROG_RUNNING_IN;
    raw.fuse_ecc             = FUSE_ECC_IN;
    raw.linear_oc            = LINEAR_OC_IN;
  end

  pmif_sync #(
    .W ($bits(pmif_pins_t))
  ) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .d     (raw),
    .q     (ps_vec)
  );

  assign ps = pmif_pins_t'(ps_vec);

  // live register images, unused bits read 0
  assign buck_live  = {3'h0, ps.buck_oc[3], ps.buck_oc[2], ps.buck_oc[1], 1'h0, ps.buck_oc[0]};
  assign boost_live = {ps.fuse_ecc, ps.fuse_running, 3'h0, ps.front_end_ov, 1'h0, ps.boost_oc};
  assign lin_live   = {2'h0, ps.linear_oc};

  // flag sources; fuse completion is the falling edge of running
  assign buck_src  = {3'h0, ps.buck_oc[3], ps.buck_oc[2], 1'h0, ps.buck_oc[1], ps.buck_oc[0]};
  assign boost_src = {ps.fuse_ecc, ~ps.fuse_running, 3'h0, ps.front_end_ov, 1'h0, ps.boost_oc};

  // strap check once the synchroniser holds valid pin levels
  assign boot_done    = (st_reg.boot == `PMIF_BOOT_DONE);
  assign strap_hit    = (st_reg.boot == `PMIF_BOOT_LAST) && !ps.front_end_supply_pin;
  assign boost_preset = strap_hit ? (8'h01 << `PMIF_FE_OV_BIT) : 8'h00;

  // bus line edges and bus conditions
  assign scl_rise = ps.scl && !st_reg.scl_d;
  assign scl_fall = !ps.scl && st_reg.scl_d;
  assign start    = ps.scl && st_reg.scl_d && st_reg.sda_d && !ps.sda;
  assign stop     = ps.scl && st_reg.scl_d && !st_reg.sda_d && ps.sda;
  assign rx_byte  = {st_reg.shreg[6:0], ps.sda};

  // register write strobe at the last data bit
  assign wr_en = scl_rise && !start && !stop && (st_reg.st == PMIF_WDAT) && (st_reg.bitcnt == `PMIF_BIT_LAST);
  assign wr_bf = wr_en && (st_reg.ptr == `PMIF_OFS_BUCK_FLAGS);
  assign wr_bm = wr_en && (st_reg.ptr == `PMIF_OFS_BUCK_MASKS);
  assign wr_sf = wr_en && (st_reg.ptr == `PMIF_OFS_BOOST_FLAGS);
  assign wr_sm = wr_en && (st_reg.ptr == `PMIF_OFS_BOOST_MASKS);
  assign wr_lf = wr_en && (st_reg.ptr == `PMIF_OFS_LIN_FLAGS);
  assign wr_lm = wr_en && (st_reg.ptr == `PMIF_OFS_LIN_MASKS);

  pmif_flag_bank #(
    .FLAG_BITS (`PMIF_BUCK_FLAG_BITS),
    .MASK_WR   (`PMIF_BUCK_MASK_WR),
    .MASK_RST  (`PMIF_BUCK_MASK_RST)
  ) u_buck (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .en       (boot_done),
    .src      (buck_src),
    .preset   (8'h00),
    .wr_flags (wr_bf),
    .wr_masks (wr_bm),
    .wdata    (rx_byte),
    .flags_q  (bf_q),
    .masks_q  (bm_q),
    .pend     (bp)
  );

  pmif_flag_bank #(
    .FLAG_BITS (`PMIF_BOOST_FLAG_BITS),
    .MASK_WR   (`PMIF_BOOST_MASK_WR),
    .MASK_RST  (`PMIF_BOOST_MASK_RST)
  ) u_boost (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .en       (boot_done),
    .src      (boost_src),
    .preset   (boost_preset),
    .wr_flags (wr_sf),
    .wr_masks (wr_sm),
    .wdata    (rx_byte),
    .flags_q  (sf_q),
    .masks_q  (sm_q),
    .pend     (sp)
  );

  pmif_flag_bank #(
    .FLAG_BITS (`PMIF_LIN_FLAG_BITS),
    .MASK_WR   (`PMIF_LIN_MASK_WR),
    .MASK_RST  (`PMIF_LIN_MASK_RST)
  ) u_lin (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .en       (boot_done),
    .src      ({2'h0, ps.linear_oc}),
    .preset   (8'h00),
    .wr_flags (wr_lf),
    .wr_masks (wr_lm),
    .wdata    (rx_byte),
    .flags_q  (lf_q),
    .masks_q  (lm_q),
    .pend     (lp)
  );

  // interrupt pin low while any bank has an unmasked flag
  assign IRQ_OUT_N = !(bp || sp || lp);

  // read multiplexer, unmapped pointers read zero
  always_comb begin
    case (st_reg.ptr)
      `PMIF_OFS_BUTTON_LIVE: rd_val = ps.s0;
      `PMIF_OFS_BUCK_FLAGS:  rd_val = bf_q;
      `PMIF_OFS_BUCK_MASKS:  rd_val = bm_q;
      `PMIF_OFS_BUCK_LIVE:   rd_val = buck_live;
      `PMIF_OFS_BOOST_FLAGS: rd_val = sf_q;
      `PMIF_OFS_BOOST_MASKS: rd_val = sm_q;
      `PMIF_OFS_BOOST_LIVE:  rd_val = boost_live;
      `PMIF_OFS_LIN_FLAGS:   rd_val = lf_q;
      `PMIF_OFS_LIN_MASKS:   rd_val = lm_q;
      `PMIF_OFS_LIN_LIVE:    rd_val = lin_live;
      default:               rd_val = `PMIF_UNMAPPED_RD;
    endcase
  end

  // serial slave: bits sampled on clock rise, sda changed only after clock fall
  always_comb begin
    st_next       = st_reg;
    st_next.scl_d = ps.scl;
    st_next.sda_d = ps.sda;
    if (!boot_done) begin
      st_next.boot = st_reg.boot + 2'h1;
    end
    if (stop) begin
      st_next.st     = PMIF_IDLE;
      st_next.sda_oe = 1'h0;
    end else if (start) begin
      st_next.st     = PMIF_ADDR;
      st_next.bitcnt = 3'h0;
      st_next.sda_oe = 1'h0;
    end else begin
      case (st_reg.st)
        PMIF_ADDR, PMIF_PTR, PMIF_WDAT: begin
          if (scl_rise) begin
            st_next.shreg  = rx_byte;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == `PMIF_BIT_LAST) begin
              case (st_reg.st)
                PMIF_ADDR: begin
                  st_next.rw = rx_byte[0];
                  st_next.st = (rx_byte[7:1] == DEV_ADDR) ? PMIF_ACK_A : PMIF_IDLE;
                end
                PMIF_PTR: begin
                  st_next.ptr = rx_byte;
                  st_next.st  = PMIF_ACK_P;
                end
                default: st_next.st = PMIF_ACK_W;
              endcase
            end
          end
        end
        PMIF_ACK_A, PMIF_ACK_P, PMIF_ACK_W: begin
          if (scl_fall) begin
            if (!st_reg.sda_oe) begin
              st_next.sda_oe = 1'h1;         // pull sda low for the acknowledge
            end else begin
              st_next.sda_oe = 1'h0;
              st_next.bitcnt = 3'h0;
              case (st_reg.st)
                PMIF_ACK_A: begin
                  if (st_reg.rw) begin
                    st_next.st     = PMIF_RDAT;
                    st_next.shreg  = rd_val;
                    st_next.sda_oe = !rd_val[7];
                  end else begin
                    st_next.st = PMIF_PTR;
                  end
                end
                PMIF_ACK_P: st_next.st = PMIF_WDAT;
                default: begin
                  st_next.st  = PMIF_WDAT;
                  st_next.ptr = st_reg.ptr + 8'h01;  // auto-increment after a write
                end
              endcase
            end
          end
        end
        PMIF_RDAT: begin
          if (scl_fall) begin
            if (st_reg.bitcnt == `PMIF_BIT_LAST) begin
              st_next.sda_oe = 1'h0;             // release for the master's acknowledge
              st_next.bitcnt = 3'h0;
              st_next.st     = PMIF_RACK;
            end else begin
              st_next.bitcnt = st_reg.bitcnt + 3'h1;
              st_next.shreg  = {st_reg.shreg[6:0], 1'h0};
              st_next.sda_oe = !st_reg.shreg[6];
            end
          end
        end
        PMIF_RACK: begin
          if (scl_rise) begin
            if (ps.sda) begin
              st_next.st = PMIF_IDLE;            // not acknowledged: read ends
            end else begin
              st_next.ptr    = st_reg.ptr + 8'h01;
              st_next.bitcnt = 3'h1;
            end
          end else if (scl_fall && (st_reg.bitcnt != 3'h0)) begin
            st_next.st     = PMIF_RDAT;
            st_next.bitcnt = 3'h0;
            st_next.shreg  = rd_val;
            st_next.sda_oe = !rd_val[7];
          end
        end
        default: st_next.st = PMIF_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= '{st: PMIF_IDLE, bitcnt: 3'h0, shreg: 8'h00, rw: 1'h0, ptr: 8'h00,
                  sda_oe: 1'h0, scl_d: 1'h0, sda_d: 1'h0, boot: 2'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // open-drain data line: only ever pulled low
  assign SDA_OUT = 1'h0;
  assign SDA_OE  = st_reg.sda_oe;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  property p_button;
    boot_done |-> (ps.s0.button_level_live == $past(POWER_BUTTON_IN, `PMIF_SYNC_DEPTH));
  endproperty
  a_button: assert property (p_button) else $error("button live bit wrong");

  property p_undervolt;
    boot_done |-> (rd_val[1] == $past(UNDERVOLTAGE_IN, `PMIF_SYNC_DEPTH)) || (st_reg.ptr != `PMIF_OFS_BUTTON_LIVE);
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervoltage live bit wrong");

  property p_temp;
    boot_done && (st_reg.ptr == `PMIF_OFS_BUTTON_LIVE) |-> (rd_val[5:2] == $past(TEMP_ABOVE_IN, `PMIF_SYNC_DEPTH));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature live bits wrong");

  property p_straps;
    boot_done && (st_reg.ptr == `PMIF_OFS_BUTTON_LIVE) |->
      (rd_val[7:6] == {$past(FUSE_SUPPLY_PIN, `PMIF_SYNC_DEPTH), $past(TEST_STRAP_PIN, `PMIF_SYNC_DEPTH)});
  endproperty
  a_straps: assert property (p_straps) else $error("strap live bits wrong");

  property p_running;
    boot_done |-> (boost_live[6] == $past(FUSE_PROG_RUNNING_IN, `PMIF_SYNC_DEPTH)) && (lin_live[7:6] == 2'h0);
  endproperty
  a_running: assert property (p_running) else $error("running or linear live bits wrong");

  property p_strap_preset;
    strap_hit |=> sf_q[`PMIF_FE_OV_BIT];
  endproperty
  a_strap_preset: assert property (p_strap_preset) else $error("overvoltage flag not preset");

  property p_irq_rise;
    $rose(IRQ_OUT_N) |-> $past(wr_en);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt released without a write");

  property p_unmask;
    (wr_bm && |(bf_q & ~rx_byte)) |=> (!IRQ_OUT_N) [*2];
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmasked set flag did not assert interrupt");

  property p_buck_live;
    boot_done |-> ({buck_live[4:2], buck_live[0]} == $past(BUCK_OC_IN, `PMIF_SYNC_DEPTH));
  endproperty
  a_buck_live: assert property (p_buck_live) else $error("buck live bits wrong");
endmodule // pmif_top
`default_nettype wire

// ==== shared/pmif_pkg.sv ====
// types shared by the interrupt flag bank design
package pmif_pkg;

  // button-state live register layout, msb first
  typedef struct packed {
    logic       fuse_supply_live;
    logic       test_strap_live;
    logic [3:0] temp_live;          // [0] lowest threshold .. [3] highest
    logic       undervoltage_live;
    logic       button_level_live;
  } pmif_sense0_t;

  // every pin entering from outside the clock domain
  typedef struct packed {
    logic         scl;
    logic         sda;
    logic         front_end_supply_pin;
    pmif_sense0_t s0;
    logic [3:0]   buck_oc;          // a, b, two, three
    logic         boost_oc;
    logic         front_end_ov;
    logic         fuse_running;
    logic         fuse_ecc;
    logic [5:0]   linear_oc;
  } pmif_pins_t;

  // serial slave states, gray along the write path
  typedef enum logic [3:0] {
    PMIF_IDLE  = 4'h0,
    PMIF_ADDR  = 4'h1,
    PMIF_ACK_A = 4'h3,
    PMIF_PTR   = 4'h2,
    PMIF_ACK_P = 4'h6,
    PMIF_WDAT  = 4'h7,
    PMIF_ACK_W = 4'h5,
    PMIF_RDAT  = 4'h4,
    PMIF_RACK  = 4'hc
  } pmif_i2c_st_t;

  typedef struct packed {
    pmif_i2c_st_t st;
    logic [2:0]   bitcnt;
    logic [7:0]   shreg;
    logic         rw;
    logic [7:0]   ptr;
    logic         sda_oe;
    logic         scl_d;
    logic         sda_d;
    logic [1:0]   boot;
  } pmif_top_st_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] masks;
    logic [7:0] src_d;
  } pmif_bank_st_t;

endpackage

// ==== shared/pmif_regs.svh ====
// register offsets, bit layouts, reset values and counts of the interrupt flag banks
`ifndef PMIF_REGS_SVH
`define PMIF_REGS_SVH

`define PMIF_OFS_BUTTON_LIVE 8'h07
`define PMIF_OFS_BUCK_FLAGS  8'h08
`define PMIF_OFS_BUCK_MASKS  8'h09
`define PMIF_OFS_BUCK_LIVE   8'h0a
`define PMIF_OFS_BOOST_FLAGS 8'h0e
`define PMIF_OFS_BOOST_MASKS 8'h0f
`define PMIF_OFS_BOOST_LIVE  8'h10
`define PMIF_OFS_LIN_FLAGS   8'h11
`define PMIF_OFS_LIN_MASKS   8'h12
`define PMIF_OFS_LIN_LIVE    8'h13
`define PMIF_UNMAPPED_RD     8'h00

`define PMIF_BUCK_FLAG_BITS  8'h1b
`define PMIF_BUCK_MASK_WR    8'h7f
`define PMIF_BUCK_MASK_RST   8'h7f
`define PMIF_BOOST_FLAG_BITS 8'hc5
`define PMIF_BOOST_MASK_WR   8'hc5
`define PMIF_BOOST_MASK_RST  8'hc5
`define PMIF_LIN_FLAG_BITS   8'h3f
`define PMIF_LIN_MASK_WR     8'h3f
`define PMIF_LIN_MASK_RST    8'h3f
`define PMIF_FE_OV_BIT       2

`define PMIF_BOOT_LAST       2'h2
`define PMIF_BOOT_DONE       2'h3
`define PMIF_BIT_LAST        3'h7
`define PMIF_I2C_ADDR_DFLT   7'h08
`define PMIF_SYNC_DEPTH      2

`endif

// ==== verification/pmif_host_model.sv ====
// host-side two-wire master model that reads and writes the flag banks
`timescale 1ns/100ps
`default_nettype none
`include "pmif_regs.svh"
module pmif_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // bus idles released, clock high
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // one bit of a 200 ns clock: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low = ~b;
    #50 scl = 1'b1;
    #50 r = sda;
    #50 scl = 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    #50 sda_low = 1'b0;
    #50 scl = 1'b1;
    #50 sda_low = 1'b1;
    #50 scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #50 sda_low = 1'b1;
    #50 scl = 1'b1;
    #50 sda_low = 1'b0;
    #50;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic a);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], t);
      r[i] = t;
    end
    bit_io(ab, a);
  endtask
  // pointer then one data byte
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    byte_io({`PMIF_I2C_ADDR_DFLT, 1'b0}, 1'b1, r, a0);
    byte_io(p, 1'b1, r, a1);
    byte_io(d, 1'b1, r, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
  // pointer, repeated start, one byte read with a closing nack
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start();
    byte_io({`PMIF_I2C_ADDR_DFLT, 1'b0}, 1'b1, r, a0);
    byte_io(p, 1'b1, r, a1);
    start();
    byte_io({`PMIF_I2C_ADDR_DFLT, 1'b1}, 1'b1, r, a2);
    byte_io(8'hff, 1'b1, d, a3);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
endmodule // pmif_host_model
`default_nettype wire

// ==== verification/pmif_top_tb_top.sv ====
// self-checking bench: random pins, every register read back, random writes
`timescale 1ns/100ps
`default_nettype none
`include "pmif_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module pmif_top_tb_top;
  logic        SYS_CLK, RESET_N, scl, sda_low, SDA_OUT, SDA_OE, IRQ_OUT_N, ok, fe_pin;
  wire         sda;
  logic [21:0] pin_v, old_v;
  logic [31:0] seed;
  logic [7:0]  bf, bm, sf, sm, lf, lm, rd_v;
  int          error_cnt, checks_done;
  localparam logic [7:0] ADDRS [11] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e, 8'h0f, 8'h10,
                                        8'h11, 8'h12, 8'h13, 8'h00};
  // scl rises for the last data bit 5300 ns into a write; the next falling edge lands pins on it
  localparam int PIN_LEAD_NS = 5280;
  // open-drain wire with pull-up
  assign sda = sda_low ? 1'b0 : (SDA_OE ? SDA_OUT : 1'b1);
  pmif_top u_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ_OUT_N(IRQ_OUT_N), .POWER_BUTTON_IN(pin_v[0]),
    .UNDERVOLTAGE_IN(pin_v[1]), .TEMP_ABOVE_IN(pin_v[5:2]), .TEST_STRAP_PIN(pin_v[6]),
    .FUSE_SUPPLY_PIN(pin_v[7]), .FRONT_END_SUPPLY_PIN(fe_pin), .BUCK_OC_IN(pin_v[11:8]),
    .BOOST_OC_IN(pin_v[12]), .FRONT_END_OV_IN(pin_v[13]), .FUSE_PROG_RUNNING_IN(pin_v[14]),
    .FUSE_ECC_IN(pin_v[15]), .LINEAR_OC_IN(pin_v[21:16]));
  pmif_host_model u_host (.scl(scl), .sda_low(sda_low), .sda(sda));
  // 40 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  // xorshift step
  function automatic void step();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  // source pins placed at their flag positions
  function automatic logic [7:0] bmap(input logic [21:0] v);
    return {3'b000, v[11], v[10], 1'b0, v[9], v[8]};
  endfunction
  function automatic logic [7:0] smap(input logic [21:0] v);
    return {v[15], 4'h0, v[13], 1'b0, v[12]};
  endfunction
  function automatic logic exp_irq();
    return ~|{bf & ~bm, sf & ~sm, lf & ~lm};
  endfunction
  // expected read value of each offset
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      `PMIF_OFS_BUTTON_LIVE: return pin_v[7:0];
      `PMIF_OFS_BUCK_FLAGS:  return bf;
      `PMIF_OFS_BUCK_MASKS:  return bm;
      `PMIF_OFS_BUCK_LIVE:   return {3'b000, pin_v[11:9], 1'b0, pin_v[8]};
      `PMIF_OFS_BOOST_FLAGS: return sf;
      `PMIF_OFS_BOOST_MASKS: return sm;
      `PMIF_OFS_BOOST_LIVE:  return {pin_v[15:14], 3'b000, pin_v[13], 1'b0, pin_v[12]};
      `PMIF_OFS_LIN_FLAGS:   return lf;
      `PMIF_OFS_LIN_MASKS:   return lm;
      `PMIF_OFS_LIN_LIVE:    return {2'b00, pin_v[21:16]};
      default:               return `PMIF_UNMAPPED_RD;
    endcase
  endfunction
  // new random pins at the falling edge; rising sources latch
  task automatic drive_pins();
    old_v = pin_v;
    step();
    @(negedge SYS_CLK) pin_v = seed[21:0];
    bf |= bmap(pin_v) & ~bmap(old_v);
    sf |= smap(pin_v) & ~smap(old_v) | {1'b0, old_v[14] & ~pin_v[14], 6'h00};
    lf |= {2'b00, pin_v[21:16] & ~old_v[21:16]};
  endtask
  // random write, clear applied first; new pins land with the write strobe so a set beats the clear
  task automatic wr_reg(input logic [7:0] a);
    logic [7:0] d;
    step();
    d = seed[7:0];
    case (a)
      `PMIF_OFS_BUCK_FLAGS:  bf &= ~d;
      `PMIF_OFS_BUCK_MASKS:  bm = d & `PMIF_BUCK_MASK_WR;
      `PMIF_OFS_BOOST_FLAGS: sf &= ~d;
      `PMIF_OFS_BOOST_MASKS: sm = d & `PMIF_BOOST_MASK_WR;
      `PMIF_OFS_LIN_FLAGS:   lf &= ~d;
      `PMIF_OFS_LIN_MASKS:   lm = d & `PMIF_LIN_MASK_WR;
      default: ;
    endcase
    fork
      u_host.wr(a, d, ok);
      begin
        #PIN_LEAD_NS;
        drive_pins();
      end
    join
    `CHK(ok, 1'b1)
  endtask
  // reset with the front-end supply pin at a given level, model back to its reset values
  task automatic do_reset(input logic fe);
    RESET_N = 1'b0;
    fe_pin = fe;
    {bf, lf} = 16'h0000;
    sf = fe ? 8'h00 : (8'h01 << `PMIF_FE_OV_BIT);
    bm = `PMIF_BUCK_MASK_RST;
    sm = `PMIF_BOOST_MASK_RST;
    lm = `PMIF_LIN_MASK_RST;
    repeat (12) @(posedge SYS_CLK);
    @(negedge SYS_CLK) RESET_N = 1'b1;
    repeat (8) @(negedge SYS_CLK);
  endtask
  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence: supply pin grounded, then a mid-run reset with it high; bus moves on falling edges
  initial begin
    pin_v = '0;
    seed = 32'hc504;
    error_cnt = 0;
    checks_done = 0;
    for (int r = 0; r < 2; r++) begin
      do_reset(r[0]);
      for (int n = 0; n < 4; n++) begin
        drive_pins();
        repeat (6) @(negedge SYS_CLK);
        `CHK(IRQ_OUT_N, exp_irq())
        foreach (ADDRS[i]) begin
          u_host.rd(ADDRS[i], rd_v, ok);
          `CHK({ok, rd_v}, {1'b1, exp_reg(ADDRS[i])})
        end
        foreach (ADDRS[i]) begin
          wr_reg(ADDRS[i]);
          `CHK(IRQ_OUT_N, exp_irq())
        end
      end
    end
    test_done();
  end
  // hang guard
  initial begin
    #2500000;
    error_cnt++;
    test_done();
  end
endmodule // pmif_top_tb_top
`default_nettype wire
